// *** include/rqh_pkg.sv ***
// Purpose: shared constants and carriers for the read-back request handler
// Assumes: 40 MHz system clock, request codes arrive on the command link
// Notes: calibration store layout offsets are byte addresses, lsb byte first
package rqh_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SENS_SCLK_HZ = 1_000_000;
  // half period of the sensor serial clock, in system clocks
  localparam int unsigned SENS_HALF_CYC = (CLK_HZ / (2 * SENS_SCLK_HZ) > 0) ?
                                          CLK_HZ / (2 * SENS_SCLK_HZ) : 1;
  localparam int unsigned SENS_FRAME_BITS = 16;

  // request codes
  localparam logic [7:0] CODE_TEMPERATURE = 8'h18;
  localparam logic [7:0] CODE_CAL_ROM_READ = 8'h20;
  localparam logic [7:0] CODE_USER_ROM_READ = 8'h22;
  localparam logic [7:0] CODE_LEVEL_DAC_READ = 8'h2a;

  // temperature result layout
  localparam int unsigned TEMP_W = 14;
  localparam int unsigned TEMP_SIGN_BIT = 13;
  localparam logic [13:0] TEMP_MAG_MASK = 14'h1fff;
  localparam logic [13:0] TEMP_SIGN_MASK = 14'h2000;
  localparam int unsigned TEMP_COUNTS_PER_DEG = 32;
  localparam int unsigned TEMP_NEG_OFFSET = 8192;

  localparam int unsigned LEVEL_DAC_W = 14;
  localparam int unsigned ROM_ADDR_W = 15;
  localparam logic [14:0] ROM_MAX_ADDR = 15'h7fff;

  // response byte counts
  localparam logic [1:0] RSP_BYTES_TEMP = 2'h2;
  localparam logic [1:0] RSP_BYTES_ROM = 2'h1;
  localparam logic [1:0] RSP_BYTES_DAC = 2'h2;

  // calibration store layout: 4-byte floats and words, 2-byte attenuation frequency and level dac entries, lowest byte least significant
  localparam logic [14:0] CAL_FW_REV_OFS = 15'h002c;
  localparam logic [14:0] CAL_SYNTH_REV_OFS = 15'h0030;
  localparam logic [14:0] CAL_COND_REV_OFS = 15'h0034;
  localparam logic [14:0] CAL_REF_DAC_OFS = 15'h0054;
  localparam logic [14:0] CAL_TUNE_FREQ_OFS = 15'h00c8;
  localparam logic [14:0] CAL_TUNE_DAC_OFS = 15'h0168;
  localparam logic [14:0] CAL_TUNE_SPLINE_OFS = 15'h0208;
  localparam int unsigned CAL_TUNE_POINTS = 40;
  localparam logic [14:0] CAL_CLOSED_TCO_OFS = 15'h0300;
  localparam logic [14:0] CAL_OPEN_TCO_OFS = 15'h0314;
  localparam int unsigned CAL_TCO_POINTS = 5;
  localparam logic [14:0] CAL_LEVEL_FREQ_OFS = 15'h0329;
  localparam logic [14:0] CAL_CLOSED_PWR_OFS = 15'h060d;
  localparam logic [14:0] CAL_CLOSED_DAC_OFS = 15'h09e1;
  localparam logic [14:0] CAL_CLOSED_COEF_OFS = 15'h0bcb;
  localparam logic [14:0] CAL_OPEN_PWR_OFS = 15'h1747;
  localparam logic [14:0] CAL_OPEN_DAC_OFS = 15'h1b1b;
  localparam logic [14:0] CAL_OPEN_COEF_OFS = 15'h1d05;
  localparam int unsigned CAL_LEVEL_POINTS = 245;
  localparam int unsigned CAL_COEF_POINTS = 735;
  localparam logic [14:0] CAL_ATTEN_FREQ_OFS = 15'h0513;
  localparam int unsigned CAL_ATTEN_FREQ_POINTS = 125;
  localparam logic [14:0] CAL_ATTEN_VAL_OFS = 15'h2881;
  localparam int unsigned CAL_ATTEN_VAL_POINTS = 5520;
  localparam int unsigned CAL_WORD_BYTES = 4;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] arg;
  } rqh_req_type;

  typedef struct packed {
    logic [1:0] count;
    logic [23:0] data;
  } rqh_rsp_type;

  typedef struct packed {
    logic user_sel;
    logic [14:0] addr;
  } rqh_mem_cmd_type;

endpackage : rqh_pkg

// *** src/rqh_sensor_reader.sv ***
// Purpose: serial read of one temperature code from the sensor
// Assumes: sensor shifts its frame msb first, changes data after the falling edge
// Notes: clocks only while a reading is pending, the link is quiet otherwise
`timescale 1ns/100ps
`default_nettype none
module rqh_sensor_reader
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic sdata_pin,
  output logic sclk,
  output logic cs_n,
  output logic done,
  output logic [rqh_pkg::TEMP_W-1:0] code
);
  import rqh_pkg::*;

  localparam int CNT_W = $clog2(SENS_HALF_CYC + 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(SENS_HALF_CYC - 1);
  localparam logic [4:0] BIT_LAST = 5'(SENS_FRAME_BITS - 1);

  logic sd_meta_r;
  logic sd_sync_r;
  logic active_r;
  logic sclk_r;
  logic done_r;
  logic [CNT_W-1:0] cnt_r;
  logic [4:0] bit_r;
  logic [SENS_FRAME_BITS-1:0] shift_r;
  logic [TEMP_W-1:0] code_r;
  wire tick;
  wire last_bit;

  assign tick = active_r && (cnt_r == HALF_LAST);
  assign last_bit = (bit_r == BIT_LAST);

  always_ff @(posedge clk_sys)
  begin
    sd_meta_r <= sdata_pin;
    sd_sync_r <= sd_meta_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      active_r <= 1'b0;
      sclk_r <= 1'b0;
      cnt_r <= '0;
      bit_r <= '0;
      done_r <= 1'b0;
      shift_r <= '0;
      code_r <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      if (!active_r)
      begin
        cnt_r <= '0;
        bit_r <= '0;
        sclk_r <= 1'b0;
        active_r <= start;
      end
      else if (!tick)
        cnt_r <= cnt_r + 1'b1;
      else
      begin
        cnt_r <= '0;
        sclk_r <= !sclk_r;
        if (!sclk_r)
          shift_r <= {shift_r[SENS_FRAME_BITS-2:0], sd_sync_r};
        else if (last_bit)
        begin
          active_r <= 1'b0;
          done_r <= 1'b1;
          code_r <= shift_r[TEMP_W-1:0];
        end
        else
          bit_r <= bit_r + 1'b1;
      end
    end
  end

  assign sclk = sclk_r;
  assign cs_n = !active_r;
  assign done = done_r;
  assign code = code_r;

endmodule : rqh_sensor_reader
`default_nettype wire

// *** src/rqh_rom_fetch.sv ***
// Purpose: single byte fetch from the calibration or user store
// Assumes: store answers with mem_ack and data in the same cycle
// Notes: upper address bit is dropped, so the space folds onto itself
`timescale 1ns/100ps
`default_nettype none
module rqh_rom_fetch
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic start,
  input wire logic user_sel,
  input wire logic [15:0] addr,
  output logic mem_valid,
  output rqh_pkg::rqh_mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic done,
  output logic [7:0] rd_byte
);
  import rqh_pkg::*;

  logic busy_r;
  logic done_r;
  logic [7:0] byte_r;
  rqh_mem_cmd_type cmd_r;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      byte_r <= '0;
      cmd_r <= '0;
    end
    else
    begin
      done_r <= busy_r && mem_ack;
      if (busy_r && mem_ack)
      begin
        busy_r <= 1'b0;
        byte_r <= mem_rdata;
      end
      else if (!busy_r && start)
      begin
        busy_r <= 1'b1;
        cmd_r.user_sel <= user_sel;
        cmd_r.addr <= addr[ROM_ADDR_W-1:0] & ROM_MAX_ADDR;
      end
    end
  end

  assign mem_valid = busy_r;
  assign mem_cmd = cmd_r;
  assign done = done_r;
  assign rd_byte = byte_r;

endmodule : rqh_rom_fetch
`default_nettype wire

// *** src/rqh_readback_handler.sv ***
// Purpose: answers read-back requests from the command link
// Assumes: host logic on the same clock, sensor and stores as outside parts
// Notes: one request in flight; the response stands until the host collects it or sends a new request
`timescale 1ns/100ps
`default_nettype none
module rqh_readback_handler
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic req_valid,
  input wire rqh_pkg::rqh_req_type req,
  output logic req_ready,
  input wire logic rsp_take,
  output logic rsp_valid,
  output rqh_pkg::rqh_rsp_type rsp,
  input wire logic [rqh_pkg::LEVEL_DAC_W-1:0] level_dac_word,
  output logic [31:0] ref_dac_word,
  output logic ref_dac_valid,
  output logic sens_sclk,
  output logic sens_cs_n,
  input wire logic sens_sdata,
  output logic mem_valid,
  output rqh_pkg::rqh_mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata
);
  import rqh_pkg::*;

  typedef enum logic [2:0] {st_boot, st_idle, st_temp, st_rom} rqh_state_type;

  rqh_state_type state_r;
  rqh_state_type state_nxt;
  logic rsp_valid_r;
  rqh_rsp_type rsp_r;
  logic [31:0] ref_acc_r;
  logic ref_valid_r;
  logic [1:0] boot_idx_r;
  logic boot_wait_r;

  wire accept;
  wire is_temp;
  wire is_cal;
  wire is_user;
  wire is_dac;
  wire is_rom;
  wire boot_start;
  wire fetch_start;
  wire fetch_user;
  wire [15:0] fetch_addr;
  wire fetch_done;
  wire [7:0] fetch_byte;
  wire sens_start;
  wire sens_done;
  wire [TEMP_W-1:0] sens_code;
  wire temp_fill;
  wire rom_fill;
  wire dac_fill;
  wire rsp_fill;
  wire [23:0] temp_data;
  wire [23:0] rom_data;
  wire [23:0] dac_data;

  // request decode
  assign req_ready = (state_r == st_idle);
  assign accept = req_valid && req_ready;
  assign is_temp = (req.code == CODE_TEMPERATURE);
  assign is_cal = (req.code == CODE_CAL_ROM_READ);
  assign is_user = (req.code == CODE_USER_ROM_READ);
  assign is_dac = (req.code == CODE_LEVEL_DAC_READ);
  assign is_rom = is_cal || is_user;

  // one sensor frame per temperature request
  assign sens_start = accept && is_temp;

  // boot fetch of the reference dac word, one byte at a time
  assign boot_start = (state_r == st_boot) && !boot_wait_r;
  // request argument is the byte address
  assign fetch_start = boot_start || (accept && is_rom);
  assign fetch_user = (state_r == st_boot) ? 1'b0 : is_user;
  assign fetch_addr = (state_r == st_boot) ?
                      {1'b0, CAL_REF_DAC_OFS + 15'(boot_idx_r)} : req.arg;

  // sensor code passes through as sign plus magnitude
  assign temp_data = {10'h000, sens_code & (TEMP_SIGN_MASK | TEMP_MAG_MASK)};
  assign rom_data = {16'h0000, fetch_byte};
  // level dac word in the low bits
  assign dac_data = {10'h000, level_dac_word};

  // which layout table a calibration read lands in; feeds coverage only
  wire [ROM_ADDR_W-1:0] cal_addr;
  wire cal_in_revs;
  wire cal_in_tuning;
  wire cal_in_tco;
  wire cal_in_closed;
  wire cal_in_open;
  wire cal_in_atten;
  wire cal_mapped;

  assign cal_addr = req.arg[ROM_ADDR_W-1:0];
  assign cal_in_revs = (cal_addr >= CAL_FW_REV_OFS)
    && (cal_addr < CAL_COND_REV_OFS + 15'(3 * CAL_WORD_BYTES));
  assign cal_in_tuning = (cal_addr >= CAL_TUNE_FREQ_OFS)
    && (cal_addr < CAL_TUNE_SPLINE_OFS + 15'(CAL_TUNE_POINTS * CAL_WORD_BYTES));
  assign cal_in_tco = (cal_addr >= CAL_CLOSED_TCO_OFS)
    && (cal_addr < CAL_OPEN_TCO_OFS + 15'(CAL_TCO_POINTS * CAL_WORD_BYTES));
  assign cal_in_closed = (cal_addr >= CAL_LEVEL_FREQ_OFS) && (cal_addr < CAL_OPEN_PWR_OFS);
  assign cal_in_open = (cal_addr >= CAL_OPEN_PWR_OFS)
    && (cal_addr < CAL_OPEN_COEF_OFS + 15'(CAL_COEF_POINTS * CAL_WORD_BYTES));
  assign cal_in_atten = ((cal_addr >= CAL_ATTEN_FREQ_OFS)
    && (cal_addr < CAL_ATTEN_FREQ_OFS + 15'(2 * CAL_ATTEN_FREQ_POINTS)))
    || ((cal_addr >= CAL_ATTEN_VAL_OFS)
    && (cal_addr < CAL_ATTEN_VAL_OFS + 15'(CAL_ATTEN_VAL_POINTS * CAL_WORD_BYTES)));
  assign cal_mapped = is_cal && (cal_in_revs || cal_in_tuning || cal_in_tco
    || cal_in_closed || cal_in_open || cal_in_atten);

  assign temp_fill = (state_r == st_temp) && sens_done;
  assign rom_fill = (state_r == st_rom) && fetch_done;
  assign dac_fill = accept && is_dac;
  assign rsp_fill = temp_fill || rom_fill || dac_fill;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      st_boot:
        if (fetch_done && boot_idx_r == 2'(CAL_WORD_BYTES - 1))
          state_nxt = st_idle;
      st_idle:
        if (accept && is_temp)
          state_nxt = st_temp;
        else if (accept && is_rom)
          state_nxt = st_rom;
      st_temp:
        if (sens_done)
          state_nxt = st_idle;
      st_rom:
        if (fetch_done)
          state_nxt = st_idle;
      default:
        state_nxt = st_idle;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_r <= st_boot;
    else
      state_r <= state_nxt;
  end

  // response held until taken, replaced by a new request
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rsp_valid_r <= 1'b0;
    else if (rsp_fill)
      rsp_valid_r <= 1'b1;
    else if (accept || rsp_take)
      rsp_valid_r <= 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      rsp_r <= '0;
    else if (temp_fill)
      rsp_r <= '{count: RSP_BYTES_TEMP, data: temp_data};
    else if (rom_fill)
      rsp_r <= '{count: RSP_BYTES_ROM, data: rom_data};
    else if (dac_fill)
      rsp_r <= '{count: RSP_BYTES_DAC, data: dac_data};
  end

  // lowest address lands in the least significant byte
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      boot_idx_r <= '0;
      boot_wait_r <= 1'b0;
      ref_acc_r <= '0;
      ref_valid_r <= 1'b0;
    end
    else if (state_r == st_boot)
    begin
      if (boot_start)
        boot_wait_r <= 1'b1;
      if (fetch_done)
      begin
        boot_wait_r <= 1'b0;
        boot_idx_r <= boot_idx_r + 1'b1;
        ref_acc_r <= {fetch_byte, ref_acc_r[31:8]};
        ref_valid_r <= (boot_idx_r == 2'(CAL_WORD_BYTES - 1));
      end
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp = rsp_r;
  assign ref_dac_word = ref_acc_r;
  assign ref_dac_valid = ref_valid_r;

  rqh_sensor_reader u_sensor
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(sens_start),
    .sdata_pin(sens_sdata),
    .sclk(sens_sclk),
    .cs_n(sens_cs_n),
    .done(sens_done),
    .code(sens_code)
  );

  rqh_rom_fetch u_fetch
  (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(fetch_start),
    .user_sel(fetch_user),
    .addr(fetch_addr),
    .mem_valid(mem_valid),
    .mem_cmd(mem_cmd),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata),
    .done(fetch_done),
    .rd_byte(fetch_byte)
  );

  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  a_temp_format: assert property (
    temp_fill |=> rsp_valid && rsp.count == 2'h2 && rsp.data[23:14] == 10'h000)
    else $error("temperature response format wrong");

  a_temp_sign_bit: assert property (
    temp_fill |=> rsp.data[13] == $past(sens_code[13]))
    else $error("temperature sign bit lost");

  a_temp_magnitude: assert property (
    temp_fill |=> rsp.data[12:0] == $past(sens_code[12:0]))
    else $error("temperature magnitude altered");

  a_sensor_frame: assert property (
    (accept && is_temp) |=> !sens_cs_n [*8])
    else $error("sensor frame not started");

  a_rom_wrap_addr: assert property (
    (accept && is_rom) |=> mem_valid && mem_cmd.addr == $past(req.arg[14:0])
                           && mem_cmd.user_sel == $past(is_user))
    else $error("store address not folded");

  a_rom_one_byte: assert property (
    rom_fill |=> rsp_valid && rsp.count == 2'h1 && rsp.data == {16'h0000, $past(fetch_byte)})
    else $error("store byte response wrong");

  a_dac_readback: assert property (
    dac_fill |=> rsp_valid && rsp.data == {10'h000, $past(level_dac_word)})
    else $error("level dac readback wrong");

  a_rsp_held: assert property (
    (rsp_valid && !rsp_take && !accept) |=> rsp_valid && $stable(rsp))
    else $error("response dropped before collection");

  a_rsp_count: assert property (
    rsp_valid |-> rsp.count >= 2'h1 && rsp.count <= 2'h3)
    else $error("response byte count out of range");

  a_ref_word_order: assert property (
    $rose(ref_dac_valid) |-> ref_dac_word[31:24] == $past(fetch_byte))
    else $error("reference word byte order wrong");

  a_boot_done: assert property (
    $rose(ref_dac_valid) |-> ##1 req_ready)
    else $error("boot did not finish after reference word");

  // serial clock rises within the current sensor frame
  logic sclk_d_r;
  logic [4:0] rise_cnt_r;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      sclk_d_r <= 1'b0;
      rise_cnt_r <= '0;
    end
    else
    begin
      sclk_d_r <= sens_sclk;
      if (sens_cs_n)
        rise_cnt_r <= '0;
      else if (sens_sclk && !sclk_d_r)
        rise_cnt_r <= rise_cnt_r + 1'b1;
    end
  end

  a_sclk_quiet: assert property (
    sens_cs_n |-> !sens_sclk)
    else $error("sensor clock runs outside a frame");

  a_sensor_clocks: assert property (
    $rose(sens_cs_n) |-> rise_cnt_r == 5'(SENS_FRAME_BITS))
    else $error("sensor frame clock count wrong");

  a_unknown_code: assert property (
    (accept && !is_temp && !is_rom && !is_dac) |=> !rsp_valid)
    else $error("unknown request left a response");

  a_rsp_upper_zero: assert property (
    (rsp_valid && rsp.count == RSP_BYTES_ROM) |-> rsp.data[23:8] == 16'h0000)
    else $error("store response upper bytes not zero");

  a_boot_address: assert property (
    (mem_valid && state_r == st_boot) |-> !mem_cmd.user_sel
                                          && mem_cmd.addr[14:2] == CAL_REF_DAC_OFS[14:2])
    else $error("boot fetch outside the reference word");

  a_ref_word_hold: assert property (
    ref_dac_valid |=> ref_dac_valid && $stable(ref_dac_word))
    else $error("reference word changed after boot");

  c_temp_read: cover property (temp_fill ##[1:4] rsp_take);
  c_rom_read: cover property (rom_fill ##1 rsp_valid);
  c_replace: cover property (rsp_valid && accept);
  c_dac_read: cover property (dac_fill);
  c_cal_table: cover property (accept && cal_mapped);

endmodule : rqh_readback_handler
`default_nettype wire

// *** dv/rqh_far_model.sv ***
// Purpose: far side of the handler: calibration and user stores, temperature sensor
// Assumes: store answers after ack_wait cycles; bench gives the sensor frame
// Notes: released data lines show the inverse of their last value
`timescale 1ns/100ps
`default_nettype none
module rqh_far_model
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] frame,
  input wire logic [3:0] ack_wait,
  input wire logic sens_sclk,
  input wire logic sens_cs_n,
  output logic sens_sdata,
  input wire logic mem_valid,
  input wire rqh_pkg::rqh_mem_cmd_type mem_cmd,
  output logic mem_ack,
  output logic [7:0] mem_rdata
);
  import rqh_pkg::*;
  logic [3:0] wait_cnt;
  int bit_idx;
  function automatic logic [7:0] fbyte(input logic u, input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ (u ? 8'ha5 : 8'h3c);
  endfunction : fbyte
  initial sens_sdata = 1'b0;
  // one byte per read of either store
  always_ff @(posedge clk_sys)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!nrst || !mem_valid || mem_ack)
      wait_cnt <= 4'h0;
    else if (wait_cnt == ack_wait)
    begin
      mem_ack <= 1'b1;
      mem_rdata <= fbyte(mem_cmd.user_sel, mem_cmd.addr);
    end
    else
      wait_cnt <= wait_cnt + 4'h1;
  end
  // serial sensor frame, msb first, shifted after the falling clock
  always @(negedge sens_cs_n)
  begin
    bit_idx = 15;
    sens_sdata = frame[15];
  end
  always @(negedge sens_sclk)
    if (!sens_cs_n && bit_idx > 0)
    begin
      bit_idx = bit_idx - 1;
      sens_sdata = frame[bit_idx];
    end
  always @(posedge sens_cs_n) sens_sdata = ~sens_sdata;
endmodule : rqh_far_model
`default_nettype wire

// *** dv/rqh_readback_handler_tb.sv ***
// Purpose: self-checking bench for the read-back request handler
// Assumes: bench plays the host; far model plays stores and sensor
// Notes: temperature reads are few, each costs a full sensor frame
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module rqh_readback_handler_tb;
  import rqh_pkg::*;
  logic clk_sys = 1'b0, nrst = 1'b0, req_valid = 1'b0, rsp_take = 1'b0;
  logic req_ready, rsp_valid, ref_dac_valid, sens_sclk, sens_cs_n, sens_sdata;
  logic mem_valid, mem_ack;
  rqh_req_type req = '0;
  rqh_rsp_type rsp;
  rqh_mem_cmd_type mem_cmd;
  logic [13:0] level_dac_word = 14'h0000;
  logic [31:0] ref_dac_word;
  logic [7:0] mem_rdata;
  logic [15:0] frame = 16'h0000;
  logic [3:0] ack_wait = 4'h0;
  int err_total = 0, n_compared = 0, sclk_rises = 0;
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge sens_sclk) sclk_rises++;
  rqh_readback_handler u_dut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_take(rsp_take), .rsp_valid(rsp_valid),
    .rsp(rsp), .level_dac_word(level_dac_word), .ref_dac_word(ref_dac_word),
    .ref_dac_valid(ref_dac_valid), .sens_sclk(sens_sclk), .sens_cs_n(sens_cs_n),
    .sens_sdata(sens_sdata), .mem_valid(mem_valid), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  rqh_far_model u_far (.clk_sys(clk_sys), .nrst(nrst), .frame(frame),
    .ack_wait(ack_wait), .sens_sclk(sens_sclk), .sens_cs_n(sens_cs_n),
    .sens_sdata(sens_sdata), .mem_valid(mem_valid), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  function automatic logic [7:0] fbyte(input logic u, input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ (u ? 8'ha5 : 8'h3c);
  endfunction : fbyte
  task automatic results;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // host side: request first, a separate read collects later
  task automatic send(input logic [7:0] c, input logic [15:0] a);
    int n;
    n = 0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{code: c, arg: a};
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (n >= 2000) `CHK("req_ready", 1'b1, req_ready)
  endtask : send
  task automatic collect(input logic [1:0] cn, input logic [23:0] d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (rsp_valid !== 1'b1 && n < 2000)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("rsp.count", cn, rsp.count)
    `CHK("rsp.data", d, rsp.data)
    @(posedge clk_sys);
    rsp_take <= 1'b1;
    @(posedge clk_sys);
    rsp_take <= 1'b0;
    @(negedge clk_sys);
    `CHK("rsp_valid after take", 1'b0, rsp_valid)
  endtask : collect
  task automatic rom_read(input logic u, input logic [15:0] a);
    send(u ? CODE_USER_ROM_READ : CODE_CAL_ROM_READ, a);
    @(negedge clk_sys);
    `CHK("mem_cmd", {1'b1, u, a[14:0]}, {mem_valid, mem_cmd})
    collect(2'h1, {16'h0000, fbyte(u, a[14:0])});
  endtask : rom_read
  task automatic t_boot;
    int n;
    logic [31:0] w;
    n = 0;
    w = {fbyte(1'b0, 15'h57), fbyte(1'b0, 15'h56), fbyte(1'b0, 15'h55),
      fbyte(1'b0, CAL_REF_DAC_OFS)};
    while (ref_dac_valid !== 1'b1 && n < 200)
    begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("ref_dac_word", w, ref_dac_word)
  endtask : t_boot
  task automatic t_level_dac;
    logic [13:0] w [3] = '{14'h0000, 14'h3fff, 14'h2a55};
    foreach (w[i])
    begin
      @(posedge clk_sys);
      level_dac_word <= w[i];
      send(CODE_LEVEL_DAC_READ, 16'h0000);
      collect(2'h2, {10'h000, w[i]});
    end
  endtask : t_level_dac
  task automatic t_cal_rom;
    logic [15:0] a [10] = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff, 16'h002c,
      16'h0208, 16'h0300, 16'h060d, 16'h1d05, 16'h2881};
    ack_wait <= 4'h0;
    foreach (a[i]) rom_read(1'b0, a[i]);
  endtask : t_cal_rom
  task automatic t_user_rom;
    logic [15:0] a [3] = '{16'h7fff, 16'h8001, 16'h0329};
    ack_wait <= 4'h5;
    foreach (a[i]) rom_read(1'b1, a[i]);
    ack_wait <= 4'h0;
  endtask : t_user_rom
  // only two readings: each frame's clocking disturbs the output
  task automatic t_temperature;
    logic [13:0] e [2];
    e[0] = 14'(25 * TEMP_COUNTS_PER_DEG);
    e[1] = TEMP_SIGN_MASK | 14'(TEMP_NEG_OFFSET - 10 * TEMP_COUNTS_PER_DEG);
    foreach (e[i])
    begin
      frame <= {2'b11, e[i]};
      sclk_rises = 0;
      send(CODE_TEMPERATURE, 16'h0000);
      collect(2'h2, {10'h000, e[i]});
      `CHK("sensor clocks", SENS_FRAME_BITS, sclk_rises)
      `CHK("sens_cs_n idle", 1'b1, sens_cs_n)
    end
  endtask : t_temperature
  task automatic t_replace;
    @(posedge clk_sys);
    level_dac_word <= 14'h1234;
    send(CODE_LEVEL_DAC_READ, 16'h0000);
    repeat (6) @(negedge clk_sys);
    `CHK("rsp stands", 1'b1, rsp_valid)
    rom_read(1'b0, 16'h0010);
    send(CODE_LEVEL_DAC_READ, 16'h0000);
    send(8'h55, 16'h0000);
    repeat (6) @(negedge clk_sys);
    `CHK("unknown code clears", 1'b0, rsp_valid)
  endtask : t_replace
  task automatic t_mid_reset;
    logic [5:0] s;
    send(CODE_TEMPERATURE, 16'h0000);
    repeat (60) @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    s = {sens_cs_n, sens_sclk, rsp_valid, mem_valid, ref_dac_valid, req_ready};
    `CHK("reset outputs", 6'b100000, s)
    @(posedge clk_sys);
    nrst <= 1'b1;
    t_boot();
    rom_read(1'b0, 16'h0054);
  endtask : t_mid_reset
  initial
  begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_boot();
    t_level_dac();
    t_cal_rom();
    t_user_rom();
    t_temperature();
    t_replace();
    t_mid_reset();
    results();
  end
  initial
  begin
    #500000;
    err_total++;
    results();
  end
endmodule : rqh_readback_handler_tb
`default_nettype wire
